// ==== common/ctu_edge_if.sv ====
// Interface: one edge channel's configuration and its detected response
`timescale 1ns/1ps
interface ctu_edge_if;
  logic [3:0] source;
  logic polarity;
  logic edge_sensitive;
  logic hit;
  modport ctl (output source, output polarity, output edge_sensitive, input hit);
  modport det (input source, input polarity, input edge_sensitive, output hit);
endinterface : ctu_edge_if

// ==== common/ctu_pkg.sv ====
// Package: register map, field positions and source codes of the charge time unit
package ctu_pkg;
  localparam int ADDR_W = 2;
  localparam logic [1:0] OFF_CTRL = 2'h0;
  localparam logic [1:0] OFF_CUR = 2'h1;
  localparam logic [1:0] OFF_E2 = 2'h2;
  localparam logic [1:0] OFF_E1 = 2'h3;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'hBF;
  localparam logic [7:0] E2_MASK = 8'hFC;
  localparam int B_EN = 7;
  localparam int B_SIDL = 5;
  localparam int B_DELAY_GENERATION_ENABLE = 4;
  localparam int B_GATE = 3;
  localparam int B_ORDER = 2;
  localparam int B_DISCH = 1;
  localparam int B_TRIG = 0;
  localparam int B_SENS = 7;
  localparam int B_POL = 6;
  localparam int SRC_HI = 5;
  localparam int SRC_LO = 2;
  localparam int B_ST2 = 1;
  localparam int B_ST1 = 0;
  localparam int TRIM_HI = 7;
  localparam int TRIM_LO = 2;
  localparam int RNG_HI = 1;
  localparam int RNG_LO = 0;
  localparam int NSRC = 16;
  localparam logic [3:0] SRC_RESERVED = 4'hC;
endpackage : ctu_pkg

// ==== hdl/ctu_edge_detect.sv ====
// Edge channel detector: source select, 3-flop sync, polarity and sensitivity
`timescale 1ns/1ps
module ctu_edge_detect
  import ctu_pkg::*;
#(
  parameter int NS = NSRC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [NS-1:0] src_i,
  ctu_edge_if.det ch
);
  typedef struct packed {
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [NS-1:0] s3;
    logic [NS-1:0] filt;
    logic [NS-1:0] filt_d;
  } ctu_det_t;
  ctu_det_t st;
  ctu_det_t next_st;
  logic lvl_now;
  logic lvl_old;

  // Synchroniser chain; stage one feeds only stage two
  always_comb begin
    next_st = st;
    if (ce_i) begin
      next_st.s1 = src_i;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // Filtered level moves only where stages two and three agree
      next_st.filt = (st.s2 & st.s3) | (st.filt & (st.s2 ^ st.s3));
      next_st.filt_d = st.filt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Reserved code never responds; polarity flips the active level
  always_comb begin
    lvl_now = (ch.source != SRC_RESERVED) && (st.filt[ch.source] == ch.polarity); // R13 R12
    lvl_old = (ch.source != SRC_RESERVED) && (st.filt_d[ch.source] == ch.polarity);
    // Edge mode needs a newly active filtered level, level mode just the level
    ch.hit = ch.edge_sensitive ? (lvl_now && !lvl_old) : lvl_now; // R11 R19
  end
endmodule : ctu_edge_detect

// ==== hdl/ctu_top.sv ====
// Charge time unit: Wishbone registers, edge sequencing and current gate
//
// Behaviour
// R01: Enable bit turns whole unit on/off; code gates only edge events, trigger and source_on_o.
// R02: Stop-in-idle halts unit during idle; code gates only edge events and trigger.
// R03: Delay-generation bit selects edge delay mode.
// R04: Edge gate bit passes or blocks edges.
// R05: Order bit: channel 2 waits channel 1.
// R06: Discharge bit grounds current source output.
// R07: Trigger bit allows conversion start event.
// R08: Control bit 6 reads zero, ignores writes.
// R09: Six-bit signed trim field, bits 7:2.
// R10: Two-bit range field selects current multiple.
// R11: Channel 2 sensitivity: edge or level.
// R12: Channel 2 polarity: high/rising or low/falling.
// R13: Four-bit channel 2 source, 1100 reserved.
// R14: Status bits 1:0 show channel events.
// R15: Detected enabled edge sets status bit.
// R16: Source on when exactly one status set.
// R17: Software may write status bits directly.
// R18: Interrupt flag when source turns off.
// R19: Channel 1 has same config fields.
// R20: All control fields reset to zero.
`timescale 1ns/1ps
module ctu_top
  import ctu_pkg::*;
#(
  parameter int NS = NSRC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic idle_i,
  input wire logic [NS-1:0] chan1_src_i,
  input wire logic [NS-1:0] chan2_src_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  output logic source_on_o,
  output logic discharge_ground_o,
  output logic delay_mode_o,
  output logic [5:0] current_trim_o,
  output logic [1:0] current_range_o,
  output logic conversion_trigger_o,
  output logic irq_flag_o
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] cur;
    logic [7:0] e2;
    logic [7:0] e1;
    logic ack;
    logic [7:0] rdat;
    logic src_on;
    logic irq;
    logic trig;
  } ctu_state_t;
  ctu_state_t st;
  ctu_state_t next_st;

  ctu_edge_if ch1_if();
  ctu_edge_if ch2_if();
  logic running;
  logic wr_hit;
  logic rd_hit;
  logic ev1;
  logic ev2;
  logic [1:0] stat_n;
  logic on_n;

  // Register read mux, reused for bus data
  function automatic logic [7:0] rd_mux(input logic [1:0] a, input ctu_state_t s);
    case (a)
      OFF_CTRL: rd_mux = s.ctrl & CTRL_MASK; // R08
      OFF_CUR: rd_mux = s.cur;
      OFF_E2: rd_mux = s.e2 & E2_MASK;
      OFF_E1: rd_mux = s.e1; // R14
      default: rd_mux = REG_RESET;
    endcase
  endfunction : rd_mux

  // Channel configuration out of the registers
  assign ch1_if.edge_sensitive = st.e1[B_SENS]; // R19
  assign ch1_if.polarity = st.e1[B_POL];
  assign ch1_if.source = st.e1[SRC_HI:SRC_LO];
  assign ch2_if.edge_sensitive = st.e2[B_SENS]; // R11
  assign ch2_if.polarity = st.e2[B_POL]; // R12
  assign ch2_if.source = st.e2[SRC_HI:SRC_LO]; // R13

  ctu_edge_detect #(.NS(NS)) u_ch1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .src_i(chan1_src_i),
    .ch(ch1_if)
  );
  ctu_edge_detect #(.NS(NS)) u_ch2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .src_i(chan2_src_i),
    .ch(ch2_if)
  );

  // Unit runs when enabled and not parked by idle
  assign running = st.ctrl[B_EN] && !(idle_i && st.ctrl[B_SIDL]); // R01 R02
  // Single-cycle ack; ack drops the cycle after it is given
  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i && !st.ack;
  assign rd_hit = wb_cyc_i && wb_stb_i && !st.ack;
  // Gated, ordered events; channel 2 waits for channel 1 status when ordered
  assign ev1 = running && st.ctrl[B_GATE] && ch1_if.hit; // R04 R15
  assign ev2 = running && st.ctrl[B_GATE] && ch2_if.hit
               && (!st.ctrl[B_ORDER] || st.e1[B_ST1]); // R05

  always_comb begin
    next_st = st;
    stat_n = st.e1[B_ST2:B_ST1];
    on_n = st.src_on;
    if (ce_i) begin
      next_st.ack = rd_hit;
      if (rd_hit) begin
        next_st.rdat = rd_mux(wb_adr_i, st);
      end
      if (wr_hit) begin
        case (wb_adr_i)
          OFF_CTRL: next_st.ctrl = wb_dat_i & CTRL_MASK; // R08 R01 R03 R06 R07
          OFF_CUR: next_st.cur = wb_dat_i; // R09 R10
          OFF_E2: next_st.e2 = wb_dat_i & E2_MASK;
          OFF_E1: begin
            next_st.e1[7:2] = wb_dat_i[7:2];
            stat_n = wb_dat_i[B_ST2:B_ST1]; // R17
          end
          default: next_st.ctrl = st.ctrl;
        endcase
      end
      // Hardware set wins over a same-cycle software clear
      if (ev1) begin
        stat_n[B_ST1] = 1'b1; // R15
      end
      if (ev2) begin
        stat_n[B_ST2] = 1'b1; // R15
      end
      next_st.e1[B_ST2:B_ST1] = stat_n; // R14
      on_n = stat_n[0] ^ stat_n[1]; // R16
      next_st.src_on = on_n;
      // Pulse when current source goes from on to off
      next_st.irq = st.src_on && !on_n; // R18
      // Conversion start when the second edge closes the window
      next_st.trig = st.ctrl[B_TRIG] && st.src_on && !on_n && running; // R07
    end
  end

  // Whole state resets to zero, unit disabled with edges blocked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0; // R20
    end else begin
      st <= next_st;
    end
  end

  // Outputs from flip-flops
  assign wb_dat_o = st.rdat;
  assign wb_ack_o = st.ack;
  assign source_on_o = st.src_on && st.ctrl[B_EN]; // R16 R01
  assign discharge_ground_o = st.ctrl[B_DISCH]; // R06
  assign delay_mode_o = st.ctrl[B_DELAY_GENERATION_ENABLE]; // R03
  assign current_trim_o = st.cur[TRIM_HI:TRIM_LO]; // R09
  assign current_range_o = st.cur[RNG_HI:RNG_LO]; // R10
  assign conversion_trigger_o = st.trig;
  assign irq_flag_o = st.irq;

  // Checks
  a_bit6_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.ctrl[6]) else $error("control bit 6 set"); // R08
  a_src_xor: assert property (@(posedge clk_i) disable iff (rst_i)
    st.src_on == (st.e1[1] ^ st.e1[0])) else $error("source gate mismatch"); // R16
  a_irq_fall: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && $fell(st.src_on) |-> st.irq) else $error("irq missing"); // R18
  a_gate_block: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !st.ctrl[B_GATE] && !wr_hit && !st.e1[0] |=> !st.e1[0]) else $error("edge leaked"); // R04
  a_order_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st.ctrl[B_ORDER] && !st.e1[0] && !wr_hit && !st.e1[1] |=> !st.e1[1])
    else $error("chan2 before chan1"); // R05
  a_trig_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    conversion_trigger_o |-> $past(st.ctrl[B_TRIG])) else $error("trigger not enabled"); // R07
  a_status_set: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ev1 |=> st.e1[0]) else $error("status not set"); // R15
  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held"); // R17

  // Bus request taken on an enabled edge
  sequence s_bus_taken;
    ce_i && rd_hit;
  endsequence
  // Software status write setting exactly one status bit, with no hardware event in that cycle
  sequence s_one_status_written;
    ce_i && wr_hit && (wb_adr_i == OFF_E1) && !ev1 && !ev2
      && (wb_dat_i[B_ST2] ^ wb_dat_i[B_ST1]);
  endsequence

  a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    s_bus_taken |=> wb_ack_o) else $error("ack missing after request"); // R14
  a_manual_on: assert property (@(posedge clk_i) disable iff (rst_i)
    s_one_status_written |=> st.src_on) else $error("manual source enable lost"); // R17
  a_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.ctrl[B_EN] |-> !source_on_o) else $error("source on while disabled"); // R01
  a_idle_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && idle_i && st.ctrl[B_SIDL] && !wr_hit && (st.e1[B_ST2:B_ST1] == 2'b00)
    |=> (st.e1[B_ST2:B_ST1] == 2'b00)) else $error("status moved in idle"); // R02
  a_reserved_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (ch1_if.source == SRC_RESERVED) |-> !ch1_if.hit) else $error("reserved code hit"); // R13
endmodule : ctu_top

// ==== tb/ctu_src_model.sv ====
// Edge source model: drives the selected lines, toggles all others
`timescale 1ns/1ps
module ctu_src_model (
  input wire logic clk_i,
  input wire logic [3:0] code1_i,
  input wire logic [3:0] code2_i,
  input wire logic lvl1_i,
  input wire logic lvl2_i,
  output logic [15:0] chan1_src_o,
  output logic [15:0] chan2_src_o
);
  logic [15:0] noise = 16'hA5C3;
  // Idle lines never sit still, so a wrong source select shows up
  always_ff @(posedge clk_i) noise <= ~noise;
  // Selected line carries the commanded level
  always_comb begin
    chan1_src_o = noise;
    chan2_src_o = ~noise;
    chan1_src_o[code1_i] = lvl1_i;
    chan2_src_o[code2_i] = lvl2_i;
  end
endmodule : ctu_src_model

// ==== tb/testbench.sv ====
// Testbench: registers, edge order and current gate of the charge time unit
`timescale 1ns/1ps
module testbench;
  import ctu_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic idle_i = 0;
  logic wb_cyc_i = 0;
  logic wb_stb_i = 0;
  logic wb_we_i = 0;
  logic wb_sel_i = 0;
  logic [1:0] wb_adr_i = 0;
  logic [7:0] wb_dat_i = 0;
  logic [7:0] q;
  logic [7:0] d;
  logic [7:0] c;
  logic [7:0] u;
  logic lvl1 = 0;
  logic lvl2 = 0;
  logic [3:0] code1 = 0;
  logic [3:0] code2 = 0;
  logic [15:0] chan1_src_i;
  logic [15:0] chan2_src_i;
  logic [7:0] wb_dat_o;
  logic wb_ack_o, source_on_o, discharge_ground_o, delay_mode_o;
  logic conversion_trigger_o, irq_flag_o;
  logic [5:0] current_trim_o;
  logic [1:0] current_range_o;
  logic [31:0] seed = 32'h0D3B906B;
  int error_cnt = 0;
  int n_tests = 0;
  int irq_cnt = 0;
  int trg_cnt = 0;
  always #50 clk_i = ~clk_i;
  // Pulses last one cycle, so count them as they pass
  always @(posedge clk_i) begin
    irq_cnt += (irq_flag_o === 1'b1);
    trg_cnt += (conversion_trigger_o === 1'b1);
  end
  ctu_top DUT (.clk_i, .rst_i, .ce_i(1'b1), .idle_i, .chan1_src_i, .chan2_src_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o,
    .wb_ack_o, .source_on_o, .discharge_ground_o, .delay_mode_o, .current_trim_o,
    .current_range_o, .conversion_trigger_o, .irq_flag_o);
  ctu_src_model src (.clk_i, .code1_i(code1), .code2_i(code2), .lvl1_i(lvl1),
    .lvl2_i(lvl2), .chan1_src_o(chan1_src_i), .chan2_src_o(chan2_src_i));
  task test_done;
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task chk(input logic [7:0] seen, input logic [7:0] expd);
    n_tests++;
    if (seen !== expd) begin
      error_cnt++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, expd);
    end
  endtask : chk
  // One classic cycle; request held until ack is sampled
  task wb(input logic w, input logic [1:0] a, input logic [7:0] dw);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_sel_i <= 1;
    wb_adr_i <= a;
    wb_dat_i <= dw;
    for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge clk_i);
    if (wb_ack_o !== 1'b1) begin
      error_cnt++;
      test_done();
    end
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    wb_sel_i <= 0;
  endtask : wb
  // Status follows the synchronizer, so re-read a bounded number of times
  task poll(input logic [1:0] a, input logic [7:0] e);
    for (int i = 0; i < 20; i++) begin
      wb(0, a, 8'h00);
      if (q === e) break;
    end
    chk(q, e);
  endtask : poll
  task settle;
    repeat (10) @(posedge clk_i);
  endtask : settle
  function automatic logic [7:0] exp_rd(input logic [1:0] a, input logic [7:0] v);
    return (a == OFF_CTRL) ? (v & CTRL_MASK) : (a == OFF_E2) ? (v & E2_MASK) : v;
  endfunction : exp_rd
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  initial begin
    c = 0;
    u = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    for (int a = 0; a < 4; a++) begin
      wb(0, a[1:0], 8'h00);
      chk(q, REG_RESET);
    end
    // Random fields; unit kept off and edges blocked so status stays put
    for (int k = 0; k < 16; k++) begin
      seed = xs(seed);
      d = seed[7:0] & ((k % 4 == 0) ? 8'h77 : (k % 4 == 3) ? 8'hFC : 8'hFF);
      if (k % 4 == 0) c = d;
      if (k % 4 == 1) u = d;
      wb(1, k[1:0], d);
      wb(0, k[1:0], 8'h00);
      chk(q, exp_rd(k[1:0], d));
      chk({delay_mode_o, discharge_ground_o, 6'h00}, {c[B_DELAY_GENERATION_ENABLE], c[B_DISCH], 6'h00});
      chk({current_trim_o, current_range_o}, u);
    end
    wb(1, OFF_E2, 8'h00);
    wb(1, OFF_E1, 8'h00);
    wb(1, OFF_CTRL, 8'h80);
    wb(1, OFF_E1, 8'h01);
    poll(OFF_E1, 8'h01);
    chk({7'h0, source_on_o}, 8'h01);
    wb(1, OFF_E1, 8'h03);
    poll(OFF_E1, 8'h03);
    chk({7'h0, source_on_o}, 8'h00);
    chk(8'(irq_cnt), 8'h01);
    // Ordered pair: channel 2 first must be ignored
    wb(1, OFF_CTRL, 8'h00);
    code1 <= 4'h6;
    code2 <= 4'h9;
    wb(1, OFF_E1, 8'hD8);
    wb(1, OFF_E2, 8'hE4);
    wb(1, OFF_CTRL, 8'h8D);
    lvl2 <= 1;
    settle();
    wb(0, OFF_E1, 8'h00);
    chk(q, 8'hD8);
    lvl1 <= 1;
    poll(OFF_E1, 8'hD9);
    chk({7'h0, source_on_o}, 8'h01);
    lvl2 <= 0;
    settle();
    lvl2 <= 1;
    poll(OFF_E1, 8'hDB);
    chk({7'h0, source_on_o}, 8'h00);
    chk({8'(irq_cnt)}, 8'h02);
    chk({8'(trg_cnt)}, 8'h01);
    // Stop in idle, then level mode once idle ends
    lvl2 <= 0;
    wb(1, OFF_CTRL, 8'h00);
    wb(1, OFF_E1, 8'h58);
    idle_i <= 1;
    wb(1, OFF_CTRL, 8'hA8);
    settle();
    wb(0, OFF_E1, 8'h00);
    chk(q, 8'h58);
    idle_i <= 0;
    poll(OFF_E1, 8'h59);
    // Blocked edges, then the reserved source code
    wb(1, OFF_CTRL, 8'h80);
    wb(1, OFF_E1, 8'h58);
    settle();
    wb(0, OFF_E1, 8'h00);
    chk(q, 8'h58);
    code1 <= 4'hC;
    wb(1, OFF_E1, 8'h70);
    wb(1, OFF_CTRL, 8'h88);
    settle();
    wb(0, OFF_E1, 8'h00);
    chk(q, 8'h70);
    test_done();
  end
endmodule : testbench
